// ### design/smartcard_cfg_pkg.sv
// constants, carriers and states of the smart-card configuration header tail
package smartcard_cfg_pkg;

    // byte offsets in configuration space
    localparam logic [7:0] SUBSYS_VENDOR_OFS = 8'h2c;
    localparam logic [7:0] SUBSYS_OFS        = 8'h2e;
    localparam logic [7:0] CAP_PTR_OFS       = 8'h34;
    localparam logic [7:0] INT_LINE_OFS      = 8'h3c;
    localparam logic [7:0] INT_PIN_OFS       = 8'h3d;
    localparam logic [7:0] MIN_GNT_OFS       = 8'h3e;
    localparam logic [7:0] SUBSYS_ACCESS_OFS = 8'h50;

    // reset and fixed values
    localparam logic [15:0] SUBSYS_RESET     = 16'h0000;
    localparam logic [7:0]  CAP_PTR_VALUE    = 8'h44;
    localparam logic [7:0]  INT_LINE_RESET   = 8'hff;
    localparam logic [7:0]  MIN_GNT_RESET    = 8'h07;
    localparam logic [7:0]  INT_PIN_RESET    = 8'h01;
    localparam logic [2:0]  PIN_CODE_BASE    = 3'h1;
    localparam logic [7:0]  UNMAPPED_BYTE    = 8'h00;

    // field layout
    localparam int ID_W        = 16;
    localparam int PIN_W       = 3;
    localparam int INT_LINES   = 4;
    localparam int LAT_W       = 8;
    localparam int LANES       = 4;

    // one configuration access, dword address plus byte enables
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [5:0]  dword_addr;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } cfg_rsp_t;

    typedef enum logic [1:0] {
        LAT_IDLE    = 2'b00,
        LAT_COUNT   = 2'b01,
        LAT_EXPIRED = 2'b11
    } lat_state_t;

endpackage : smartcard_cfg_pkg

// ### design/latency_counter.sv
// latency timer of the bus initiator: counts from frame start, asks to end on grant loss
`timescale 1ns/100ps
module latency_counter #(
    parameter int CNT_W = smartcard_cfg_pkg::LAT_W
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             frame_active,
    input  wire logic             grant_active,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  expired,
    output logic                  end_request
);

    generate
        if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
            $error("latency_counter: CNT_W out of range");
        end
    endgenerate

    smartcard_cfg_pkg::lat_state_t state_reg;
    smartcard_cfg_pkg::lat_state_t state_next;
    logic [CNT_W-1:0]              cnt_reg;
    logic [CNT_W-1:0]              cnt_next;
    logic                          expired_reg;
    logic                          end_request_reg;

    wire limit_hit = (cnt_reg == limit);
    wire is_expired_next = (state_next == smartcard_cfg_pkg::LAT_EXPIRED);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            smartcard_cfg_pkg::LAT_IDLE: begin
                cnt_next = '0;
                if (frame_active) begin
                    state_next = smartcard_cfg_pkg::LAT_COUNT; // [RULE_13]
                end
            end
            smartcard_cfg_pkg::LAT_COUNT: begin
                if (!frame_active) begin
                    state_next = smartcard_cfg_pkg::LAT_IDLE;
                end else if (limit_hit) begin
                    state_next = smartcard_cfg_pkg::LAT_EXPIRED; // [RULE_13]
                end else begin
                    cnt_next = cnt_reg + 1'b1; // [RULE_13]
                end
            end
            smartcard_cfg_pkg::LAT_EXPIRED: begin
                if (!frame_active) begin
                    state_next = smartcard_cfg_pkg::LAT_IDLE;
                end
            end
            default: begin
                state_next = smartcard_cfg_pkg::LAT_IDLE;
                cnt_next   = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg       <= smartcard_cfg_pkg::LAT_IDLE;
            cnt_reg         <= '0;
            expired_reg     <= 1'b0;
            end_request_reg <= 1'b0;
        end else begin
            state_reg       <= state_next;
            cnt_reg         <= cnt_next;
            expired_reg     <= is_expired_next;
            end_request_reg <= is_expired_next && frame_active && !grant_active; // [RULE_13]
        end
    end

    assign expired     = expired_reg;
    assign end_request = end_request_reg;

endmodule : latency_counter

// ### design/smartcard_pci_config_tail.sv
// upper configuration header of the smart-card function: ids, pointers, interrupt routing
//
// Overview of operation
// RULE_01: subsystem ids read-only, eeprom loaded, reset zero
// RULE_02: ids change only through access register
// RULE_03: only global reset clears subsystem ids
// RULE_04: capabilities pointer fixed, points to 44h
// RULE_05: interrupt line read/write, resets to ffh
// RULE_06: pin value from select bits, 01h..04h
// RULE_07: forced input overrides select, highest priority wins
// RULE_08: tie-all bit forces first interrupt input
// RULE_09: tie-all clear forces no interrupt input
// RULE_10: pin register upper five bits zero
// RULE_11: minimum grant resets 07h, hardware updated
// RULE_12: host picks latency timer from minimum grant
// RULE_13: latency timer ends transaction after grant loss
// RULE_14: writes to read-only registers complete silently
`timescale 1ns/100ps
module smartcard_pci_config_tail #(
    parameter int ID_BITS  = smartcard_cfg_pkg::ID_W,
    parameter int LAT_BITS = smartcard_cfg_pkg::LAT_W
) (
    input  wire logic                        ref_clk,
    input  wire logic                        arst_n,
    input  wire logic                        bus_rst_n,
    input  wire smartcard_cfg_pkg::cfg_req_t cfg_req,
    output smartcard_cfg_pkg::cfg_rsp_t      cfg_rsp,
    input  wire logic                        eeprom_load_valid,
    input  wire logic [2*ID_BITS-1:0]        eeprom_subsys_ids,
    input  wire logic                        min_gnt_update_valid,
    input  wire logic [7:0]                  min_gnt_update_value,
    input  wire logic [1:0]                  int_sel,
    input  wire logic                        tie_all_interrupts_bit,
    input  wire logic                        frame_active,
    input  wire logic                        bus_gnt_n,
    input  wire logic [LAT_BITS-1:0]         latency_timer_value,
    output logic [3:0]                       forced_interrupt_inputs,
    output logic [7:0]                       interrupt_pin_value,
    output logic [7:0]                       interrupt_line_assignment,
    output logic                             latency_expired,
    output logic                             end_transaction
);

    generate
        if (ID_BITS != 16) begin : g_bad_id
            $error("smartcard_pci_config_tail: ID_BITS must be 16");
        end
        if (LAT_BITS != 8) begin : g_bad_lat
            $error("smartcard_pci_config_tail: LAT_BITS must be 8");
        end
    endgenerate

    // reset release and pin synchronisers
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic bus_rst_meta_reg;
    logic bus_rst_sync_reg;
    logic gnt_meta_reg;
    logic gnt_sync_reg;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    wire rst_n = rst_sync_reg;

    // bus reset counts as asserted while the global reset holds
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rst_meta_reg <= 1'b0;
            bus_rst_sync_reg <= 1'b0;
            gnt_meta_reg     <= 1'b1;
            gnt_sync_reg     <= 1'b1;
        end else begin
            bus_rst_meta_reg <= bus_rst_n;
            bus_rst_sync_reg <= bus_rst_meta_reg;
            gnt_meta_reg     <= bus_gnt_n;
            gnt_sync_reg     <= gnt_meta_reg;
        end
    end

    wire bus_reset_active = !bus_rst_sync_reg;
    wire grant_active     = !gnt_sync_reg;

    // access decode
    wire cfg_wr = cfg_req.valid && cfg_req.write;
    wire cfg_rd = cfg_req.valid && !cfg_req.write;

    wire access_hit   = (cfg_req.dword_addr == smartcard_cfg_pkg::SUBSYS_ACCESS_OFS[7:2]);
    wire int_line_hit = (cfg_req.dword_addr == smartcard_cfg_pkg::INT_LINE_OFS[7:2]);
    wire int_line_be  = cfg_req.byte_en[smartcard_cfg_pkg::INT_LINE_OFS[1:0]];
    wire int_line_we  = cfg_wr && int_line_hit && int_line_be; // [RULE_05]

    // registers
    logic [ID_BITS-1:0]  subsys_vendor_ident_reg;
    logic [ID_BITS-1:0]  subsys_vendor_ident_next;
    logic [ID_BITS-1:0]  subsys_ident_reg;
    logic [ID_BITS-1:0]  subsys_ident_next;
    logic [7:0]          int_line_reg;
    logic [7:0]          int_line_next;
    logic [7:0]          min_gnt_reg;
    logic [7:0]          min_gnt_next;
    logic [3:0]          forced_reg;
    logic [3:0]          forced_next;
    logic [7:0]          int_pin_reg;
    logic [7:0]          int_pin_next;
    logic                ack_reg;
    logic [31:0]         rdata_reg;
    logic [31:0]         rdata_next;

    // per byte lane: access-register write enables and read data
    logic [3:0]          access_we;
    logic [31:0]         access_wdata;
    logic [31:0]         ids_merged;

    genvar lane;
    generate
        for (lane = 0; lane < smartcard_cfg_pkg::LANES; lane++) begin : g_lane
            wire [7:0] lane_addr = {cfg_req.dword_addr, 2'(lane)};
            logic [7:0] lane_data;

            // config writes move the ids only through the access dword, never their own offsets
            assign access_we[lane] = cfg_wr && access_hit && cfg_req.byte_en[lane]; // [RULE_02]
            assign ids_merged[8*lane +: 8] = access_we[lane] ? cfg_req.wdata[8*lane +: 8]
                                                              : access_wdata[8*lane +: 8];

            always_comb begin
                lane_data = smartcard_cfg_pkg::UNMAPPED_BYTE;
                case (lane_addr)
                    smartcard_cfg_pkg::SUBSYS_VENDOR_OFS:
                        lane_data = subsys_vendor_ident_reg[7:0];
                    8'(smartcard_cfg_pkg::SUBSYS_VENDOR_OFS + 8'h01):
                        lane_data = subsys_vendor_ident_reg[15:8];
                    smartcard_cfg_pkg::SUBSYS_OFS:
                        lane_data = subsys_ident_reg[7:0];
                    8'(smartcard_cfg_pkg::SUBSYS_OFS + 8'h01):
                        lane_data = subsys_ident_reg[15:8];
                    smartcard_cfg_pkg::CAP_PTR_OFS:
                        lane_data = smartcard_cfg_pkg::CAP_PTR_VALUE; // [RULE_04]
                    smartcard_cfg_pkg::INT_LINE_OFS:
                        lane_data = int_line_reg; // [RULE_05]
                    smartcard_cfg_pkg::INT_PIN_OFS:
                        lane_data = int_pin_reg; // [RULE_10]
                    smartcard_cfg_pkg::MIN_GNT_OFS:
                        lane_data = min_gnt_reg; // [RULE_11]
                    default:
                        lane_data = smartcard_cfg_pkg::UNMAPPED_BYTE;
                endcase
            end

            // disabled lanes read as zero so a partial read never shows stale bytes
            assign rdata_next[8*lane +: 8] = cfg_req.byte_en[lane] ? lane_data
                                                                    : smartcard_cfg_pkg::UNMAPPED_BYTE;
        end
    endgenerate

    assign access_wdata = {subsys_ident_reg, subsys_vendor_ident_reg};

    // eeprom load takes priority over a same-cycle access write
    assign subsys_vendor_ident_next = eeprom_load_valid ? eeprom_subsys_ids[ID_BITS-1:0]
                                                        : ids_merged[ID_BITS-1:0]; // [RULE_01]
    assign subsys_ident_next        = eeprom_load_valid ? eeprom_subsys_ids[2*ID_BITS-1:ID_BITS]
                                                        : ids_merged[2*ID_BITS-1:ID_BITS]; // [RULE_01]

    // the ids sit on the global reset only, so a bus reset keeps them
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            subsys_vendor_ident_reg <= smartcard_cfg_pkg::SUBSYS_RESET; // [RULE_03]
            subsys_ident_reg        <= smartcard_cfg_pkg::SUBSYS_RESET; // [RULE_03]
        end else begin
            subsys_vendor_ident_reg <= subsys_vendor_ident_next;
            subsys_ident_reg        <= subsys_ident_next;
        end
    end

    // interrupt line: host programmed, bus reset returns it to unassigned
    always_comb begin
        int_line_next = int_line_reg;
        if (bus_reset_active) begin
            int_line_next = smartcard_cfg_pkg::INT_LINE_RESET; // [RULE_05]
        end else if (int_line_we) begin
            int_line_next = cfg_req.wdata[8*smartcard_cfg_pkg::INT_LINE_OFS[1:0] +: 8]; // [RULE_05]
        end
    end

    // minimum grant: config writes never reach it, only the hardware update and the bus reset
    always_comb begin
        min_gnt_next = min_gnt_reg;
        if (bus_reset_active) begin
            min_gnt_next = smartcard_cfg_pkg::MIN_GNT_RESET; // [RULE_11]
        end else if (min_gnt_update_valid) begin
            min_gnt_next = min_gnt_update_value; // [RULE_11]
        end
    end

    // forced inputs: tie-all drives only the first one
    assign forced_next = {3'h0, tie_all_interrupts_bit}; // [RULE_08] [RULE_09]

    // interrupt pin: lowest asserted forced input wins, else the select bits
    logic [1:0] pin_index;

    always_comb begin
        pin_index = int_sel; // [RULE_06]
        for (int i = smartcard_cfg_pkg::INT_LINES - 1; i >= 0; i--) begin
            if (forced_reg[i]) begin
                pin_index = 2'(i); // [RULE_07]
            end
        end
    end

    wire [smartcard_cfg_pkg::PIN_W-1:0] pin_code = 3'({1'b0, pin_index}) + smartcard_cfg_pkg::PIN_CODE_BASE;

    assign int_pin_next = {5'h00, pin_code}; // [RULE_10]

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_line_reg <= smartcard_cfg_pkg::INT_LINE_RESET;
            min_gnt_reg  <= smartcard_cfg_pkg::MIN_GNT_RESET;
            forced_reg   <= 4'h0;
            int_pin_reg  <= smartcard_cfg_pkg::INT_PIN_RESET;
        end else begin
            int_line_reg <= int_line_next;
            min_gnt_reg  <= min_gnt_next;
            forced_reg   <= forced_next;
            int_pin_reg  <= int_pin_next;
        end
    end

    // every access answers one cycle later; writes to read-only bytes just drop
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= cfg_req.valid; // [RULE_14]
            rdata_reg <= cfg_rd ? rdata_next : 32'h0000_0000;
        end
    end

    // the host sets the latency timer from minimum grant; this side only counts it
    latency_counter #(
        .CNT_W (LAT_BITS)
    ) u_latency (
        .clk          (ref_clk),
        .rst_n        (rst_n),
        .frame_active (frame_active),
        .grant_active (grant_active),
        .limit        (latency_timer_value), // [RULE_12]
        .expired      (latency_expired),
        .end_request  (end_transaction)
    );

    assign cfg_rsp.ack                = ack_reg;
    assign cfg_rsp.rdata              = rdata_reg;
    assign forced_interrupt_inputs    = forced_reg;
    assign interrupt_pin_value        = int_pin_reg;
    assign interrupt_line_assignment  = int_line_reg;

endmodule : smartcard_pci_config_tail

// ### dv/smartcard_pci_config_tail_props.sv
// port assertions of the configuration header tail
`timescale 1ns/100ps
module smartcard_pci_config_tail_props #(
    parameter int ID_BITS  = 16,
    parameter int LAT_BITS = 8
) (
    input wire logic                        ref_clk,
    input wire logic                        arst_n,
    input wire logic                        bus_rst_n,
    input wire smartcard_cfg_pkg::cfg_req_t cfg_req,
    input wire smartcard_cfg_pkg::cfg_rsp_t cfg_rsp,
    input wire logic                        eeprom_load_valid,
    input wire logic [2*ID_BITS-1:0]        eeprom_subsys_ids,
    input wire logic                        min_gnt_update_valid,
    input wire logic [7:0]                  min_gnt_update_value,
    input wire logic [1:0]                  int_sel,
    input wire logic                        tie_all_interrupts_bit,
    input wire logic                        frame_active,
    input wire logic                        bus_gnt_n,
    input wire logic [LAT_BITS-1:0]         latency_timer_value,
    input wire logic [3:0]                  forced_interrupt_inputs,
    input wire logic [7:0]                  interrupt_pin_value,
    input wire logic [7:0]                  interrupt_line_assignment,
    input wire logic                        latency_expired,
    input wire logic                        end_transaction
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire rd_cap  = cfg_req.valid && !cfg_req.write && cfg_req.dword_addr == 6'h0d && cfg_req.byte_en[0];
    wire wr_line = cfg_req.valid && cfg_req.write && cfg_req.dword_addr == 6'h0f && cfg_req.byte_en[0];
    sequence s_start;
        ($rose(frame_active) && latency_timer_value == LAT_BITS'(3)) ##1 frame_active[*4];
    endsequence
    property p_ack; cfg_rsp.ack == $past(cfg_req.valid); endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
    property p_wr_zero; cfg_req.valid && cfg_req.write |=> cfg_rsp.rdata == 32'h0; endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
    property p_cap; rd_cap |=> cfg_rsp.rdata[7:0] == 8'h44; endproperty
    a_cap: assert property (p_cap) else $error("capability pointer wrong");
    property p_forced; forced_interrupt_inputs == {3'h0, $past(tie_all_interrupts_bit)}; endproperty
    a_forced: assert property (p_forced) else $error("forced inputs do not follow tie-all");
    property p_pin_hi; interrupt_pin_value[7:3] == 5'h00; endproperty
    a_pin_hi: assert property (p_pin_hi) else $error("pin upper bits set");
    property p_pin_forced; forced_interrupt_inputs[0] |=> interrupt_pin_value == 8'h01; endproperty
    a_pin_forced: assert property (p_pin_forced) else $error("forced pin not 01");
    property p_pin_sel;
        !$past(forced_interrupt_inputs[0]) |-> interrupt_pin_value == {6'h00, $past(int_sel)} + 8'h01;
    endproperty
    a_pin_sel: assert property (p_pin_sel) else $error("pin does not follow select");
    property p_line;
        interrupt_line_assignment != $past(interrupt_line_assignment)
            |-> $past(wr_line) || $past(wr_line, 2) || interrupt_line_assignment == 8'hff;
    endproperty
    a_line: assert property (p_line) else $error("line changed without write");
    property p_lat; s_start |-> !latency_expired ##1 latency_expired; endproperty
    a_lat: assert property (p_lat) else $error("latency expiry off count");
    property p_frame_clr; !frame_active |=> !latency_expired && !end_transaction; endproperty
    a_frame_clr: assert property (p_frame_clr) else $error("latency flags not cleared");
    property p_end; end_transaction |-> latency_expired; endproperty
    a_end: assert property (p_end) else $error("end before expiry");
endmodule : smartcard_pci_config_tail_props

bind smartcard_pci_config_tail smartcard_pci_config_tail_props #(.ID_BITS(ID_BITS), .LAT_BITS(LAT_BITS)) u_props (
    .ref_clk, .arst_n, .bus_rst_n, .cfg_req, .cfg_rsp, .eeprom_load_valid, .eeprom_subsys_ids,
    .min_gnt_update_valid, .min_gnt_update_value, .int_sel, .tie_all_interrupts_bit, .frame_active,
    .bus_gnt_n, .latency_timer_value, .forced_interrupt_inputs, .interrupt_pin_value,
    .interrupt_line_assignment, .latency_expired, .end_transaction);

// ### dv/cfg_host_model.sv
// host bridge model issuing configuration cycles
`timescale 1ns/100ps
module cfg_host_model (
    input  wire logic                        ref_clk,
    output smartcard_cfg_pkg::cfg_req_t      cfg_req,
    input  wire smartcard_cfg_pkg::cfg_rsp_t cfg_rsp,
    output logic [7:0]                       lat_val
);
    initial begin
        cfg_req = '0;
        lat_val = 8'h00;
    end
    // released fields inverted so a stale request is never mistaken for a live one
    task automatic access(input logic w, input logic [5:0] dw, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        ok = 1'b0;
        rd = 32'h0;
        @(negedge ref_clk);
        cfg_req = '{1'b1, w, dw, be, wd};
        @(negedge ref_clk);
        cfg_req = '{1'b0, ~w, ~dw, ~be, ~wd};
        // ack stands one cycle from the taking edge itself, so look before waiting
        for (int i = 0; i < 4 && !ok; i++) begin
            if (cfg_rsp.ack === 1'b1) begin
                ok = 1'b1;
                rd = cfg_rsp.rdata;
            end else begin
                @(negedge ref_clk);
            end
        end
    endtask : access
    task automatic set_latency(output logic ok);
        logic [31:0] d;
        access(1'b0, 6'h0f, 4'h4, 32'h0, d, ok);
        lat_val = d[23:16];
    endtask : set_latency
endmodule : cfg_host_model

// ### dv/smartcard_pci_config_tail_tb_top.sv
// self-checking bench of the configuration header tail
`timescale 1ns/100ps
module smartcard_pci_config_tail_tb_top;
    logic ref_clk = 1'b0, arst_n = 1'b0, bus_rst_n = 1'b1, eeprom_load_valid = 1'b0;
    logic min_gnt_update_valid = 1'b0, tie_all = 1'b0, frame_active = 1'b0, bus_gnt_n = 1'b0;
    logic [31:0] ids = 32'h0;
    logic [7:0]  mg_val = 8'h00, lat_val, pin, line;
    logic [1:0]  int_sel = 2'h0;
    logic [3:0]  forced;
    logic        expired, end_t;
    smartcard_cfg_pkg::cfg_req_t req;
    smartcard_cfg_pkg::cfg_rsp_t rsp;
    int bad_count = 0, n_checks = 0;
    always #20 ref_clk = ~ref_clk;
    cfg_host_model host (.ref_clk(ref_clk), .cfg_req(req), .cfg_rsp(rsp), .lat_val(lat_val));
    smartcard_pci_config_tail uut (
        .ref_clk(ref_clk), .arst_n(arst_n), .bus_rst_n(bus_rst_n), .cfg_req(req), .cfg_rsp(rsp),
        .eeprom_load_valid(eeprom_load_valid), .eeprom_subsys_ids(ids),
        .min_gnt_update_valid(min_gnt_update_valid), .min_gnt_update_value(mg_val), .int_sel(int_sel),
        .tie_all_interrupts_bit(tie_all), .frame_active(frame_active), .bus_gnt_n(bus_gnt_n),
        .latency_timer_value(lat_val), .forced_interrupt_inputs(forced), .interrupt_pin_value(pin),
        .interrupt_line_assignment(line), .latency_expired(expired), .end_transaction(end_t));
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    task automatic acc(input logic w, input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd,
                       input logic [31:0] exp, input string nm);
        logic [31:0] d;
        logic        ok;
        host.access(w, dw, be, wd, d, ok);
        if (!ok) begin
            bad_count++;
            stop_test();
        end else begin
            chk(nm, exp, d);
        end
    endtask : acc
    task automatic t_reset_vals;
        acc(1'b0, 6'h0b, 4'hf, 32'h0, 32'h0, "subsystem ids");
        acc(1'b0, 6'h0d, 4'hf, 32'h0, 32'h44, "cap pointer");
        acc(1'b0, 6'h0f, 4'hf, 32'h0, 32'h000701ff, "dword 3c");
        acc(1'b0, 6'h10, 4'hf, 32'h0, 32'h0, "unmapped");
    endtask : t_reset_vals
    task automatic t_ro_writes;
        acc(1'b1, 6'h0b, 4'hf, 32'hffffffff, 32'h0, "write ids");
        acc(1'b1, 6'h0d, 4'hf, 32'hffffffff, 32'h0, "write cap");
        acc(1'b1, 6'h0f, 4'he, 32'hffffffff, 32'h0, "write pin mingnt");
        acc(1'b1, 6'h10, 4'hf, 32'hffffffff, 32'h0, "write unmapped");
        t_reset_vals();
    endtask : t_ro_writes
    task automatic t_line;
        acc(1'b1, 6'h0f, 4'h1, 32'hffffff0a, 32'h0, "write line");
        acc(1'b0, 6'h0f, 4'h1, 32'h0, 32'h0a, "line read");
        chk("line port", 32'h0a, {24'h0, line});
    endtask : t_line
    task automatic t_subsys;
        acc(1'b1, 6'h14, 4'hf, 32'h5a5a1234, 32'h0, "access write");
        acc(1'b0, 6'h0b, 4'hf, 32'h0, 32'h5a5a1234, "ids after access");
        acc(1'b1, 6'h14, 4'h4, 32'h00c30000, 32'h0, "lane write");
        acc(1'b0, 6'h0b, 4'hf, 32'h0, 32'h5ac31234, "ids after lane");
        acc(1'b0, 6'h14, 4'hf, 32'h0, 32'h0, "access read");
        ids = 32'h9876abcd;
        eeprom_load_valid = 1'b1;
        tick(1);
        eeprom_load_valid = 1'b0;
        acc(1'b0, 6'h0b, 4'hf, 32'h0, 32'h9876abcd, "ids after load");
    endtask : t_subsys
    task automatic t_bus_reset;
        bus_rst_n = 1'b0;
        tick(5);
        chk("line bus reset", 32'hff, {24'h0, line});
        bus_rst_n = 1'b1;
        tick(4);
        acc(1'b0, 6'h0b, 4'hf, 32'h0, 32'h9876abcd, "ids keep bus reset");
    endtask : t_bus_reset
    task automatic t_global_reset_input;
        arst_n = 1'b0;
        tick(2);
        arst_n = 1'b1;
        tick(4);
        acc(1'b0, 6'h0b, 4'hf, 32'h0, 32'h0, "ids after global");
    endtask : t_global_reset_input
    task automatic t_min_gnt;
        logic ok;
        mg_val = 8'h03;
        min_gnt_update_valid = 1'b1;
        tick(1);
        min_gnt_update_valid = 1'b0;
        acc(1'b0, 6'h0f, 4'h4, 32'h0, 32'h00030000, "min grant");
        host.set_latency(ok);
        chk("latency ack", 32'h1, {31'h0, ok});
        chk("latency value", 32'h03, {24'h0, lat_val});
    endtask : t_min_gnt
    task automatic t_pin;
        for (int s = 0; s < 4; s++) begin
            int_sel = 2'(s);
            tick(2);
            chk("pin port", 32'(s + 1), {24'h0, pin});
            acc(1'b0, 6'h0f, 4'h2, 32'h0, 32'(s + 1) << 8, "pin read");
        end
        tie_all = 1'b1;
        tick(3);
        chk("forced on", 32'h1, {28'h0, forced});
        chk("pin forced", 32'h01, {24'h0, pin});
        tie_all = 1'b0;
        tick(3);
        chk("forced off", 32'h0, {28'h0, forced});
        chk("pin select", 32'h04, {24'h0, pin});
        int_sel = 2'h0;
    endtask : t_pin
    task automatic t_latency;
        frame_active = 1'b1;
        tick(6);
        chk("expired", 32'h1, {31'h0, expired});
        chk("end with grant", 32'h0, {31'h0, end_t});
        bus_gnt_n = 1'b1;
        tick(4);
        chk("end grant lost", 32'h1, {31'h0, end_t});
        frame_active = 1'b0;
        tick(2);
        chk("flags cleared", 32'h0, {30'h0, expired, end_t});
        bus_gnt_n = 1'b0;
    endtask : t_latency
    initial begin
        tick(12);
        arst_n = 1'b1;
        tick(4);
        t_reset_vals();
        t_ro_writes();
        t_line();
        t_subsys();
        t_bus_reset();
        t_global_reset_input();
        t_min_gnt();
        t_pin();
        t_latency();
        stop_test();
    end
endmodule : smartcard_pci_config_tail_tb_top
